// ===== verilog/tms_cfg.svh
`ifndef TMS_CFG_SVH
`define TMS_CFG_SVH

// ****************************************
// Register addresses
// ****************************************
`define TMS_ADDR_CFG       16'h28A0
`define TMS_ADDR_GO        16'h28B4
`define TMS_ADDR_RES_HI    16'h2881
`define TMS_ADDR_RES_LO    16'h2882

// ****************************************
// Field positions
// ****************************************
`define TMS_CFG_IVL_HI     2
`define TMS_CFG_IVL_LO     0
`define TMS_CFG_BATT_EN    4
`define TMS_CFG_SUPPLY     6
`define TMS_CFG_BATT_SEL   7
`define TMS_GO_BIT         6
`define TMS_RES_LO_HI      7
`define TMS_RES_LO_LO      5
`define TMS_RES_MSB        10
`define TMS_RES_SPLIT      3

// ****************************************
// Reset values and interval codes
// ****************************************
`define TMS_RST_IVL        3'h0
`define TMS_RST_BIT        1'h0
`define TMS_RST_BYTE       8'h00
`define TMS_RST_RESULT     11'h000
`define TMS_IVL_OFF        3'h0
`define TMS_IVL_CONT       3'h7
`define TMS_IVL_EXP_BASE   4'h3
`define TMS_IVL_MAX_EXP    9

`endif

// ===== verilog/tms_pkg.sv
package tms_pkg;

   typedef enum logic [0:0] {
      TMS_IDLE = 1'b0,
      TMS_MEAS = 1'b1
   } tms_state_t;

   typedef logic [2:0]  tms_ivl_t;
   typedef logic [10:0] tms_result_t;

endpackage : tms_pkg

// ===== verilog/tms_sched_if.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Link between control and interval timer
// ****************************************
interface tms_sched_if;
   tms_pkg::tms_ivl_t interval;
   logic              sec_tick;
   logic              due_ack;
   logic              due;

   modport ctl   (output interval, output sec_tick, output due_ack, input due);
   modport sched (input interval, input sec_tick, input due_ack, output due);
endinterface : tms_sched_if

`default_nettype wire

// ===== verilog/tms_sched.sv
`timescale 1ns/1ps
`default_nettype none
`include "tms_cfg.svh"

module tms_sched #(
   parameter int CNT_W = 9
) (
   input  wire logic    clk_i,    // System clock
   input  wire logic    rst_b_i,  // Async reset, active low
   tms_sched_if.sched   sif       // Link to control
);

   generate
      if (CNT_W < `TMS_IVL_MAX_EXP) begin : g_chk
         $error("tms_sched: CNT_W too small for longest interval");
      end
   endgenerate

   // ****************************************
   // Last count of a periodic interval
   // ****************************************
   function automatic logic [CNT_W-1:0] last_count(input tms_pkg::tms_ivl_t ivl);
      logic [CNT_W:0] one;
      one = {{CNT_W{1'b0}}, 1'b1};
      last_count = CNT_W'((one << (`TMS_IVL_EXP_BASE + 4'(ivl))) - one);
   endfunction : last_count

   function automatic logic is_periodic(input tms_pkg::tms_ivl_t ivl);
      is_periodic = (ivl != `TMS_IVL_OFF) && (ivl != `TMS_IVL_CONT);
   endfunction : is_periodic

   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic              due_q;
   logic              due_d;
   tms_pkg::tms_ivl_t ivl_q;

   always_comb begin
      cnt_d = cnt_q;
      due_d = due_q;
      if (sif.due_ack) begin
         due_d = 1'b0;
      end
      if (sif.interval != ivl_q || !is_periodic(sif.interval)) begin
         cnt_d = '0;
         due_d = 1'b0;
      end else if (sif.sec_tick) begin
         if (cnt_q == last_count(sif.interval)) begin
            cnt_d = '0;
            due_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
         due_q <= `TMS_RST_BIT;
         ivl_q <= `TMS_RST_IVL;
      end else begin
         cnt_q <= cnt_d;
         due_q <= due_d;
         ivl_q <= sif.interval;
      end
   end

   // Continuous mode always asks; a pending due dies with its periodic code
   assign sif.due = (due_q && is_periodic(sif.interval)) || (sif.interval == `TMS_IVL_CONT);

endmodule : tms_sched

`default_nettype wire

// ===== verilog/tms_ctrl.sv
// Overview of operation
// - Interval zero: no auto runs, one-shot allowed
// - Hardware clears one-shot bit on completion
// - Sleep or display-only: one-shot bit ignored
// - Supply select: 1 main, 0 clock battery; low-power modes force clock battery
// - Low-power modes: sensor always powered
// - Battery enable adds battery measurement
// - Battery choice: 1 main, 0 clock battery
// - Eleven-bit read-only result word
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tms_cfg.svh"

module tms_ctrl #(
   parameter int CNT_W = 9
) (
   input  wire logic        clk_i,                  // System clock, 200 MHz
   input  wire logic        rst_b_i,                // Async reset, active low
   input  wire logic [15:0] addr_i,                 // Register address
   input  wire logic [7:0]  wdata_i,                // Write data
   input  wire logic        wr_i,                   // Write strobe
   input  wire logic        rd_i,                   // Read strobe
   output logic      [7:0]  rdata_o,                // Read data, next cycle
   input  wire logic        sec_tick_i,             // One-second time base pulse
   input  wire logic        sleep_state_i,          // Sleep mode active
   input  wire logic        display_only_state_i,   // Display-only mode active
   input  wire logic        meas_done_i,            // Sensor finished, pulse
   input  wire logic [10:0] meas_result_i,          // Sensor result with done
   output logic             meas_start_o,           // Start sensor, pulse
   output logic             battery_measure_o,      // Also measure battery
   output logic             battery_choice_o,       // 1 main, 0 clock battery
   output logic             sensor_power_on_o,      // Sensor powered
   output logic             main_digital_supply_o   // 1 main supply, 0 clock battery
);

   // ****************************************
   // State
   // ****************************************
   tms_pkg::tms_state_t  state_q;
   tms_pkg::tms_state_t  state_d;
   tms_pkg::tms_ivl_t    ivl_q;
   tms_pkg::tms_ivl_t    ivl_d;
   logic                 batt_en_q;
   logic                 batt_en_d;
   logic                 supply_q;
   logic                 supply_d;
   logic                 batt_sel_q;
   logic                 batt_sel_d;
   logic                 go_q;
   logic                 go_d;
   logic                 oneshot_q;
   logic                 oneshot_d;
   logic                 start_q;
   logic                 start_d;
   logic                 batt_run_q;
   logic                 batt_run_d;
   logic                 batt_chs_q;
   logic                 batt_chs_d;
   tms_pkg::tms_result_t result_q;
   tms_pkg::tms_result_t result_d;
   logic [7:0]           rdata_q;
   logic [7:0]           rdata_d;
   logic                 low_power;
   logic                 wr_cfg;
   logic                 wr_go;

   tms_sched_if sif ();

   tms_sched #(
      .CNT_W (CNT_W)
   ) u_sched (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .sif     (sif.sched)
   );

   assign low_power    = sleep_state_i || display_only_state_i;
   assign wr_cfg       = wr_i && (addr_i == `TMS_ADDR_CFG);
   assign wr_go        = wr_i && (addr_i == `TMS_ADDR_GO);
   assign sif.interval = ivl_q;
   assign sif.sec_tick = sec_tick_i;
   assign sif.due_ack  = start_q;

   // ****************************************
   // Configuration and measurement control
   // ****************************************
   always_comb begin
      state_d    = state_q;
      ivl_d      = ivl_q;
      batt_en_d  = batt_en_q;
      supply_d   = supply_q;
      batt_sel_d = batt_sel_q;
      go_d       = go_q;
      oneshot_d  = oneshot_q;
      start_d    = 1'b0;
      batt_run_d = batt_run_q;
      batt_chs_d = batt_chs_q;
      result_d   = result_q;
      if (wr_cfg) begin
         ivl_d      = wdata_i[`TMS_CFG_IVL_HI:`TMS_CFG_IVL_LO];
         batt_en_d  = wdata_i[`TMS_CFG_BATT_EN];
         supply_d   = wdata_i[`TMS_CFG_SUPPLY];
         batt_sel_d = wdata_i[`TMS_CFG_BATT_SEL];
      end
      case (state_q)
         tms_pkg::TMS_IDLE: begin
            if (sif.due && !start_q) begin
               start_d    = 1'b1;
               oneshot_d  = 1'b0;
               state_d    = tms_pkg::TMS_MEAS;
            end else if (ivl_q == `TMS_IVL_OFF && go_q && !low_power) begin
               start_d    = 1'b1;
               oneshot_d  = 1'b1;
               state_d    = tms_pkg::TMS_MEAS;
            end
            batt_run_d = batt_en_q;
            batt_chs_d = batt_sel_q;
         end
         tms_pkg::TMS_MEAS: begin
            if (meas_done_i) begin
               result_d = meas_result_i;
               state_d  = tms_pkg::TMS_IDLE;
               if (oneshot_q) begin
                  go_d = 1'b0;
               end
            end
         end
         default: begin
            state_d = tms_pkg::TMS_IDLE;
         end
      endcase
      // Software set wins over hardware clear
      if (wr_go) begin
         go_d = wdata_i[`TMS_GO_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q    <= tms_pkg::TMS_IDLE;
         ivl_q      <= `TMS_RST_IVL;
         batt_en_q  <= `TMS_RST_BIT;
         supply_q   <= `TMS_RST_BIT;
         batt_sel_q <= `TMS_RST_BIT;
         go_q       <= `TMS_RST_BIT;
         oneshot_q  <= `TMS_RST_BIT;
         start_q    <= `TMS_RST_BIT;
         batt_run_q <= `TMS_RST_BIT;
         batt_chs_q <= `TMS_RST_BIT;
         result_q   <= `TMS_RST_RESULT;
      end else begin
         state_q    <= state_d;
         ivl_q      <= ivl_d;
         batt_en_q  <= batt_en_d;
         supply_q   <= supply_d;
         batt_sel_q <= batt_sel_d;
         go_q       <= go_d;
         oneshot_q  <= oneshot_d;
         start_q    <= start_d;
         batt_run_q <= batt_run_d;
         batt_chs_q <= batt_chs_d;
         result_q   <= result_d;
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_comb begin
      rdata_d = `TMS_RST_BYTE;
      if (rd_i) begin
         case (addr_i)
            `TMS_ADDR_CFG: begin
               rdata_d[`TMS_CFG_IVL_HI:`TMS_CFG_IVL_LO] = ivl_q;
               rdata_d[`TMS_CFG_BATT_EN]                = batt_en_q;
               rdata_d[`TMS_CFG_SUPPLY]                 = supply_q;
               rdata_d[`TMS_CFG_BATT_SEL]               = batt_sel_q;
            end
            `TMS_ADDR_GO: begin
               rdata_d[`TMS_GO_BIT] = go_q;
            end
            `TMS_ADDR_RES_HI: begin
               rdata_d = result_q[`TMS_RES_MSB:`TMS_RES_SPLIT];
            end
            `TMS_ADDR_RES_LO: begin
               rdata_d[`TMS_RES_LO_HI:`TMS_RES_LO_LO] = result_q[`TMS_RES_SPLIT-1:0];
            end
            default: begin
               rdata_d = `TMS_RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= `TMS_RST_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_o               = rdata_q;
   assign meas_start_o          = start_q;
   assign battery_measure_o     = batt_run_q;
   assign battery_choice_o      = batt_chs_q;
   assign main_digital_supply_o = supply_q && !low_power;
   assign sensor_power_on_o     = low_power || (state_q == tms_pkg::TMS_MEAS) || start_q;

endmodule : tms_ctrl

`default_nettype wire

// ===== sim/tms_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module tms_sensor_model (
   input  wire logic        clk_i,   // clock
   input  wire logic        start_i, // start pulse
   input  wire logic [7:0]  lat_i,   // run length
   input  wire logic [10:0] val_i,   // value to report
   output logic             done_o,  // done pulse
   output logic [10:0]      res_o    // result
);
   int cnt = 0;
   initial done_o = 1'b0;
   initial res_o = 11'h000;
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      // Junk outside the done cycle
      res_o <= ~res_o;
      if (start_i) begin
         cnt = lat_i;
      end else if (cnt > 0) begin
         cnt--;
         if (cnt == 0) begin
            done_o <= 1'b1;
            res_o <= val_i;
         end
      end
   end
endmodule : tms_sensor_model
`default_nettype wire

// ===== sim/tms_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "tms_cfg.svh"
module tms_ctrl_properties (
   input wire logic        clk_i,                 // clock
   input wire logic        rst_b_i,               // reset
   input wire logic [15:0] addr_i,                // address
   input wire logic [7:0]  wdata_i,               // write data
   input wire logic        wr_i,                  // write
   input wire logic        rd_i,                  // read
   input wire logic [7:0]  rdata_o,               // read data
   input wire logic        sleep_state_i,         // sleep
   input wire logic        display_only_state_i,  // display only
   input wire logic        meas_done_i,           // done
   input wire logic        meas_start_o,          // start
   input wire logic        battery_measure_o,     // battery on
   input wire logic        battery_choice_o,      // battery pick
   input wire logic        sensor_power_on_o,     // powered
   input wire logic        main_digital_supply_o  // supply
);
   logic [7:0] cfg_q;
   logic       busy_q;
   logic [1:0] lat_q;
   wire logic  lp;
   assign lp = sleep_state_i | display_only_state_i;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_q <= 8'h00;
         busy_q <= 1'b0;
         lat_q <= 2'h0;
      end else begin
         if (wr_i && addr_i == `TMS_ADDR_CFG) cfg_q <= wdata_i;
         if (meas_start_o) begin
            busy_q <= 1'b1;
            lat_q <= {cfg_q[4], cfg_q[7]};
         end else if (meas_done_i) busy_q <= 1'b0;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside slot");
   a_start_single: assert property (meas_start_o |-> !busy_q ##1 !meas_start_o) else $error("start overlap");
   a_lowpwr_power: assert property (lp |-> sensor_power_on_o && !main_digital_supply_o)
      else $error("low power supply wrong");
   a_supply_sel: assert property (!lp |-> main_digital_supply_o == cfg_q[6]) else $error("supply wrong");
   a_go_start: assert property (wr_i && addr_i == `TMS_ADDR_GO && wdata_i[6] && cfg_q[2:0] == 3'h0
      && !busy_q && !meas_start_o && !lp ##1 !lp |-> ##1 meas_start_o) else $error("one-shot no start");
   a_lowpwr_nogo: assert property (lp && $past(lp) && cfg_q[2:0] == 3'h0 && $past(cfg_q[2:0]) == 3'h0
      |-> !meas_start_o) else $error("start in low power");
   a_cont_next: assert property (cfg_q[2:0] == 3'h7 && busy_q && meas_done_i |-> ##2 meas_start_o)
      else $error("continuous restart late");
   a_batt_latch: assert property (busy_q && !meas_start_o |-> {battery_measure_o, battery_choice_o} == lat_q)
      else $error("battery controls wrong");
   cover property (meas_start_o && cfg_q[2:0] == 3'h0);
   cover property (cfg_q[2:0] == 3'h7 && meas_done_i);
   cover property (lp && sensor_power_on_o);
endmodule : tms_ctrl_properties
bind tms_ctrl tms_ctrl_properties u_prop (
   .clk_i                 (clk_i),
   .rst_b_i               (rst_b_i),
   .addr_i                (addr_i),
   .wdata_i               (wdata_i),
   .wr_i                  (wr_i),
   .rd_i                  (rd_i),
   .rdata_o               (rdata_o),
   .sleep_state_i         (sleep_state_i),
   .display_only_state_i  (display_only_state_i),
   .meas_done_i           (meas_done_i),
   .meas_start_o          (meas_start_o),
   .battery_measure_o     (battery_measure_o),
   .battery_choice_o      (battery_choice_o),
   .sensor_power_on_o     (sensor_power_on_o),
   .main_digital_supply_o (main_digital_supply_o)
);
`default_nettype wire

// ===== sim/tms_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tms_cfg.svh"
module tms_ctrl_tb;
   logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, sec_tick_i = 0;
   logic sleep_state_i = 0, display_only_state_i = 0, meas_done_i, meas_start_o;
   logic battery_measure_o, battery_choice_o, sensor_power_on_o, main_digital_supply_o;
   logic [15:0] addr_i = 0;
   logic [7:0]  wdata_i = 0, rdata_o, lat = 8'h01;
   logic [10:0] val = 0, meas_result_i;
   int mismatches = 0, comparisons = 0, starts = 0, cyc = 0, s;
   always #2.5 clk_i = ~clk_i;
   tms_ctrl u_dut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sec_tick_i, .sleep_state_i,
      .display_only_state_i, .meas_done_i, .meas_result_i, .meas_start_o, .battery_measure_o,
      .battery_choice_o, .sensor_power_on_o, .main_digital_supply_o);
   tms_sensor_model u_sen (.clk_i, .start_i(meas_start_o), .lat_i(lat), .val_i(val), .done_o(meas_done_i),
      .res_o(meas_result_i));
   task automatic give_verdict();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   always @(posedge clk_i) begin
      cyc++;
      if (meas_start_o) starts++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wn(int n);
      repeat (n) @(posedge clk_i);
   endtask : wn
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rchk(logic [15:0] a, logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", {3'h0, e}, {3'h0, rdata_o});
   endtask : rchk
   task automatic tick(int n);
      repeat (n) begin
         @(posedge clk_i);
         sec_tick_i <= 1'b1;
         @(posedge clk_i);
         sec_tick_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask : tick
   task automatic t_regs();
      rchk(`TMS_ADDR_CFG, 8'h00);
      rchk(`TMS_ADDR_GO, 8'h00);
      wr(16'h1234, 8'hFF);
      rchk(16'h1234, 8'h00);
      wr(`TMS_ADDR_CFG, 8'hFE);
      rchk(`TMS_ADDR_CFG, 8'hD6);
      chk("supply", 1, main_digital_supply_o);
      wr(`TMS_ADDR_CFG, 8'h00);
      #1 chk("supply", 0, main_digital_supply_o);
      $display("regs done");
   endtask : t_regs
   task automatic t_oneshot();
      for (int i = 0; i < 2; i++) begin
         lat = i ? 8'd40 : 8'd1;
         val = 11'h5A3 ^ 11'(i);
         wr(`TMS_ADDR_CFG, i ? 8'h00 : 8'h90);
         s = starts;
         wr(`TMS_ADDR_GO, 8'h40);
         wn(3);
         chk("starts", 1, 11'(starts - s));
         chk("bat", i ? 0 : 1, battery_measure_o);
         chk("bsel", i ? 0 : 1, battery_choice_o);
         if (i) rchk(`TMS_ADDR_GO, 8'h40);
         wn(50);
         rchk(`TMS_ADDR_GO, 8'h00);
         rchk(`TMS_ADDR_RES_HI, val[10:3]);
         rchk(`TMS_ADDR_RES_LO, {val[2:0], 5'h00});
         chk("starts", 1, 11'(starts - s));
      end
      $display("oneshot done");
   endtask : t_oneshot
   task automatic t_lowpwr();
      lat = 8'd1;
      wr(`TMS_ADDR_CFG, 8'h40);
      sleep_state_i <= 1'b1;
      s = starts;
      wr(`TMS_ADDR_GO, 8'h40);
      chk("power", 1, sensor_power_on_o);
      chk("supply", 0, main_digital_supply_o);
      wn(20);
      chk("starts", 0, 11'(starts - s));
      rchk(`TMS_ADDR_GO, 8'h40);
      @(posedge clk_i);
      sleep_state_i <= 1'b0;
      display_only_state_i <= 1'b1;
      wn(20);
      chk("starts", 0, 11'(starts - s));
      chk("power", 1, sensor_power_on_o);
      @(posedge clk_i);
      display_only_state_i <= 1'b0;
      wn(10);
      chk("starts", 1, 11'(starts - s));
      $display("lowpwr done");
   endtask : t_lowpwr
   task automatic t_periodic();
      for (int n = 0; n < 7; n++) begin
         wr(`TMS_ADDR_CFG, 8'(n));
         s = starts;
         tick((8 << n) - 1);
         chk("early", 0, 11'(starts - s));
         tick(1);
         wn(2);
         chk("due", n ? 1 : 0, 11'(starts - s));
      end
      $display("periodic done");
   endtask : t_periodic
   task automatic t_cont();
      lat = 8'd20;
      s = starts;
      wr(`TMS_ADDR_CFG, 8'h07);
      wn(60);
      chk("cont", 1, 11'(starts - s >= 2));
      while (!meas_start_o) @(posedge clk_i);
      wr(`TMS_ADDR_CFG, 8'h00);
      wn(40);
      s = starts;
      wn(60);
      chk("stop", 0, 11'(starts - s));
      $display("cont done");
   endtask : t_cont
   initial begin
      wn(2);
      rst_b_i <= 1'b1;
      t_regs();
      t_oneshot();
      t_lowpwr();
      t_periodic();
      t_cont();
      give_verdict();
   end
endmodule : tms_ctrl_tb
`default_nettype wire
